//--- dv/port_status_chk.sv
// Assertions on the ports of the status and control block.
// Bound to every instance of the top module.
`timescale 1ns/10ps
module port_status_chk
    import port_status_pkg::*;
(
    input wire logic         i_clk_sys,
    input wire logic         i_rst_n,
    input wire logic         i_cmd_valid,
    input wire logic [15:0]  i_cmd_word,
    input wire logic         i_port_init,
    input wire xfer_events_t i_xfer,
    input wire rx_events_t   i_rx,
    input wire logic         i_cts,
    input wire logic         i_has_cts,
    input wire logic         i_rs485,
    input wire duplex_mode_t i_duplex,
    input wire logic         i_tx_busy,
    input wire logic         o_ans_valid,
    input wire logic [15:0]  o_ans_word,
    input wire logic         o_rx_accept,
    input wire logic         o_rts,
    input wire logic         o_tx_drive_en
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    wire logic q = i_cmd_valid && i_cmd_word == CMD_READ_STATUS && !o_ans_valid;
    a_answer_two_beats: assert property (q |=> o_ans_valid [*2] ##1 !o_ans_valid)
        else $error("answer not two beats");
    a_unused_bits_zero: assert property ($rose(o_ans_valid) |-> o_ans_word[4:0] == 5'h00)
        else $error("unused status bits set");
    a_read_start_flags: assert property (i_xfer.read_start ##1 q |=>
        o_ans_word[15:13] == 3'b100) else $error("read start flags wrong");
    a_read_done_flags: assert property (i_xfer.read_finish && !i_xfer.read_start ##1 q |=>
        o_ans_word[15:14] == 2'b01) else $error("read done flags wrong");
    a_write_expire_flags: assert property (i_xfer.write_expire && !i_xfer.write_start ##1 q
        |=> !o_ans_word[12] && o_ans_word[10]) else $error("write expire flags wrong");
    a_cts_flag_level: assert property (q |=> o_ans_word[5] == $past(i_cts || !i_has_cts))
        else $error("cts flag wrong");
    a_p2p_drive_on: assert property ((!i_rs485 || i_duplex == DUPLEX_P2P) |=> o_tx_drive_en)
        else $error("driver off in point mode");
    a_multi_drive_busy: assert property (i_rs485 && i_duplex != DUPLEX_P2P |=>
        o_tx_drive_en == $past(i_tx_busy)) else $error("driver not tied to sending");
    a_rts_cmd_follow: assert property (!i_rs485 && i_cmd_valid && i_cmd_word ==
        CMD_WRITE_CONTROL ##1 i_cmd_valid && !i_rs485 |-> ##2 o_rts == $past(i_cmd_word[15], 2))
        else $error("rts not following control word");
endmodule : port_status_chk
bind serial_port_status_control port_status_chk u_chk (.*);

//--- dv/remote_serial_model.sv
// Remote serial device: answers line RTS with CTS after a lag.
// Assumes the bench clock and the line RTS of the block.
`timescale 1ns/10ps
module remote_serial_model #(
    parameter int LAG = 2
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rts,
    output logic      o_cts
);
    logic [7:0] lag_cnt = 8'h00;
    initial o_cts = 1'b0;
    always @(posedge i_clk_sys) begin
        if (i_rts != o_cts) begin
            lag_cnt <= lag_cnt + 8'h01;
            if (lag_cnt == LAG[7:0]) begin
                o_cts   <= i_rts;
                lag_cnt <= 8'h00;
            end
        end else begin
            lag_cnt <= 8'h00;
        end
    end
endmodule : remote_serial_model

//--- dv/testbench.sv
// Self-checking bench for the serial port status and control block.
// Inputs change 1 ns after the rising edge; the remote model drives CTS.
`timescale 1ns/10ps
module testbench;
    import port_status_pkg::*;
    localparam logic [15:0] C = 16'h0020;
    logic         clk_sys = 1'b0;
    logic         rst_n = 1'b0, cmd_valid = 1'b0, port_init = 1'b0;
    logic         has_cts = 1'b0, rs485 = 1'b0, tx_busy = 1'b0;
    logic [15:0]  cmd_word = 16'h0000;
    xfer_events_t xfer = '0;
    rx_events_t   rx = '0;
    duplex_mode_t duplex = DUPLEX_P2P;
    logic         ans_valid, rx_accept, rts, drive_en, cts;
    logic [15:0]  ans_word;
    int           mismatches = 0, checks_done = 0, cycles = 0;
    always #5 clk_sys = ~clk_sys;
    serial_port_status_control #(.BUF_DEPTH(8)) u_dut (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
        .i_cmd_valid(cmd_valid), .i_cmd_word(cmd_word), .i_port_init(port_init),
        .i_xfer(xfer), .i_rx(rx), .i_cts(cts), .i_has_cts(has_cts), .i_rs485(rs485),
        .i_duplex(duplex), .i_tx_busy(tx_busy), .o_ans_valid(ans_valid),
        .o_ans_word(ans_word), .o_rx_accept(rx_accept), .o_rts(rts), .o_tx_drive_en(drive_en));
    remote_serial_model u_remote (.i_clk_sys(clk_sys), .i_rts(rts), .o_cts(cts));
    ////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step
    task automatic cmd(input logic [15:0] w);
        cmd_valid = 1'b1;
        cmd_word = w;
        step(1);
        cmd_valid = 1'b0;
    endtask : cmd
    task automatic query(input logic [15:0] es, input logic [15:0] ec);
        cmd(CMD_READ_STATUS);
        chk({15'h0000, ans_valid}, 16'h0001);
        chk(ans_word, es);
        step(1);
        chk(ans_word, ec);
        step(1);
        chk({15'h0000, ans_valid}, 16'h0000);
    endtask : query
    task automatic pulse(input xfer_events_t x, input rx_events_t r);
        xfer = x;
        rx = r;
        step(1);
        xfer = '0;
        rx = '0;
    endtask : pulse
    task automatic lines(input logic [15:0] exp);
        chk({14'h0000, rts, drive_en}, exp);
    endtask : lines
    ////////////////////////////////
    task automatic t_xfer;
        pulse(8'h88, 5'h00);
        query(16'h9000 | C, 16'h0000);
        pulse(8'h44, 5'h00);
        query(16'h4800 | C, 16'h0000);
        pulse(8'h88, 5'h00);
        pulse(8'h22, 5'h00);
        query(16'h2400 | C, 16'h0000);
        pulse(8'h88, 5'h00);
        pulse(8'h11, 5'h00);
        query(C, 16'h0000);
    endtask : t_xfer
    task automatic t_rx;
        repeat (3) pulse(8'h00, 5'h10);
        query(16'h0200 | C, 16'h0003);
        pulse(8'h00, 5'h08);
        repeat (6) pulse(8'h00, 5'h10);
        chk({15'h0000, rx_accept}, 16'h0000);
        pulse(8'h00, 5'h10);
        query(16'h0320, 16'h0008);
        pulse(8'h00, 5'h07);
        query(16'h03E0, 16'h0008);
        query(16'h0220, 16'h0008);
        port_init = 1'b1;
        step(1);
        port_init = 1'b0;
        query(C, 16'h0000);
    endtask : t_rx
    task automatic t_rts;
        has_cts = 1'b1;
        cmd(CMD_WRITE_CONTROL);
        cmd(16'h8000);
        step(2);
        lines(16'h0003);
        step(4);
        query(C, 16'h0000);
        rs485 = 1'b1;
        duplex = DUPLEX_2WIRE;
        step(3);
        lines(16'h0000);
        tx_busy = 1'b1;
        step(3);
        lines(16'h0003);
        tx_busy = 1'b0;
        duplex = DUPLEX_4WIRE;
        step(3);
        lines(16'h0000);
        duplex = DUPLEX_P2P;
        step(3);
        lines(16'h0003);
        cmd(CMD_WRITE_CONTROL);
        cmd(16'h0000);
        step(6);
        lines(16'h0001);
        query(16'h0000, 16'h0000);
        cmd(CMD_WRITE_CONTROL);
        cmd(16'h8000);
        step(2);
        port_init = 1'b1;
        step(1);
        port_init = 1'b0;
        step(2);
        lines(16'h0001);
    endtask : t_rts
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            results();
        end
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        step(1);
        lines(16'h0001);
        query(C, 16'h0000);
        t_xfer();
        t_rx();
        t_rts();
        results();
    end
endmodule : testbench

//--- rtl/port_status_pkg.sv
// Package for the serial port status and control block.
// Assumes a single 100 MHz clock domain; no bus, command codes arrive on a word port.
package port_status_pkg;

    localparam logic [15:0] CMD_READ_STATUS   = 16'h10CF;
    localparam logic [15:0] CMD_WRITE_CONTROL = 16'h10D0;

    localparam int BIT_READ_ACTIVE   = 15;
    localparam int BIT_READ_DONE     = 14;
    localparam int BIT_READ_EXPIRED  = 13;
    localparam int BIT_WRITE_ACTIVE  = 12;
    localparam int BIT_WRITE_DONE    = 11;
    localparam int BIT_WRITE_EXPIRED = 10;
    localparam int BIT_RX_PENDING    = 9;
    localparam int BIT_OVERRUN       = 8;
    localparam int BIT_FRAMING       = 7;
    localparam int BIT_PARITY        = 6;
    localparam int BIT_CTS           = 5;
    localparam int BIT_RTS_CMD       = 15;

    localparam logic [15:0] STATUS_RESET  = 16'h0000;
    localparam logic [15:0] COUNT_RESET   = 16'h0000;
    localparam logic        RTS_RESET     = 1'b0;

    typedef enum logic [1:0] {
        DUPLEX_P2P   = 2'b00,
        DUPLEX_2WIRE = 2'b01,
        DUPLEX_4WIRE = 2'b10
    } duplex_mode_t;

    typedef enum logic [1:0] {
        ANS_IDLE  = 2'b00,
        ANS_WORD1 = 2'b01,
        ANS_WORD2 = 2'b10
    } answer_state_t;

    // Progress events from read and write engines
    typedef struct packed {
        logic read_start;
        logic read_finish;
        logic read_expire;
        logic read_cancel;
        logic write_start;
        logic write_finish;
        logic write_expire;
        logic write_cancel;
    } xfer_events_t;

    // Receive side events
    typedef struct packed {
        logic char_in;
        logic char_take;
        logic rx_overrun;
        logic framing_err;
        logic parity_err;
    } rx_events_t;

endpackage : port_status_pkg

//--- rtl/serial_port_status_control.sv
// Status and control logic of a serial port: status word, pending count, RTS.
// Assumes one clock, synchronous inputs, and event pulses one cycle wide.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module serial_port_status_control
    import port_status_pkg::*;
#(
    parameter int BUF_DEPTH = 2048
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst_n,
    input  wire logic         i_cmd_valid,
    input  wire logic [15:0]  i_cmd_word,
    input  wire logic         i_port_init,
    input  wire xfer_events_t i_xfer,
    input  wire rx_events_t   i_rx,
    input  wire logic         i_cts,
    input  wire logic         i_has_cts,
    input  wire logic         i_rs485,
    input  wire duplex_mode_t i_duplex,
    input  wire logic         i_tx_busy,
    output logic              o_ans_valid,
    output logic [15:0]       o_ans_word,
    output logic              o_rx_accept,
    output logic              o_rts,
    output logic              o_tx_drive_en
);

    localparam logic [15:0] DEPTH_W = 16'(BUF_DEPTH);

    ////////////////////////////////////////////////////////////////////////////
    // Command decode
    logic           ctl_pending_reg;
    logic           query;
    logic           ctl_write;
    logic [15:0]    status_word;
    logic [15:0]    count_reg;
    logic           rts_cmd_reg;
    logic           rd_act_reg;
    logic           rd_done_reg;
    logic           rd_exp_reg;
    logic           rd_act_next;
    logic           rd_done_next;
    logic           rd_exp_next;
    logic           wr_act_reg;
    logic           wr_done_reg;
    logic           wr_exp_reg;
    logic           wr_act_next;
    logic           wr_done_next;
    logic           wr_exp_next;
    logic [2:0]     err_event;
    logic [2:0]     err_reg;
    logic [15:0]    count_next;
    logic           drive_en_next;
    logic           rts_line_next;
    logic           buf_full;
    logic           drop;
    answer_state_t  ans_state_reg;
    logic [15:0]    count_snap_reg;

    assign query     = i_cmd_valid && !ctl_pending_reg && i_cmd_word == CMD_READ_STATUS;
    assign ctl_write = i_cmd_valid && ctl_pending_reg;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctl_pending_reg <= 1'b0;
        end else if (i_cmd_valid) begin
            ctl_pending_reg <= !ctl_pending_reg && i_cmd_word == CMD_WRITE_CONTROL;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transfer progress flags
    // Start wins over finish or expiry in the same cycle
    always_comb begin
        rd_act_next  = rd_act_reg;
        rd_done_next = rd_done_reg;
        rd_exp_next  = rd_exp_reg;
        if (i_xfer.read_start) begin
            rd_act_next  = 1'b1;
            rd_done_next = 1'b0;
            rd_exp_next  = 1'b0;
        end else begin
            if (i_xfer.read_finish || i_xfer.read_expire || i_xfer.read_cancel) begin
                rd_act_next = 1'b0;
            end
            if (i_xfer.read_finish) begin
                rd_done_next = 1'b1;
            end
            if (i_xfer.read_expire) begin
                rd_exp_next = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_act_reg  <= 1'b0;
            rd_done_reg <= 1'b0;
            rd_exp_reg  <= 1'b0;
        end else begin
            rd_act_reg  <= rd_act_next;
            rd_done_reg <= rd_done_next;
            rd_exp_reg  <= rd_exp_next;
        end
    end

    always_comb begin
        wr_act_next  = wr_act_reg;
        wr_done_next = wr_done_reg;
        wr_exp_next  = wr_exp_reg;
        if (i_xfer.write_start) begin
            wr_act_next  = 1'b1;
            wr_done_next = 1'b0;
            wr_exp_next  = 1'b0;
        end else begin
            if (i_xfer.write_finish || i_xfer.write_expire || i_xfer.write_cancel) begin
                wr_act_next = 1'b0;
            end
            if (i_xfer.write_finish) begin
                wr_done_next = 1'b1;
            end
            if (i_xfer.write_expire) begin
                wr_exp_next = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_act_reg  <= 1'b0;
            wr_done_reg <= 1'b0;
            wr_exp_reg  <= 1'b0;
        end else begin
            wr_act_reg  <= wr_act_next;
            wr_done_reg <= wr_done_next;
            wr_exp_reg  <= wr_exp_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input buffer occupancy
    assign buf_full = count_reg >= DEPTH_W;
    assign drop     = i_rx.char_in && buf_full && !i_rx.char_take;

    // Simultaneous arrival and take leave the count unchanged unless it is zero, when it rises by one
    always_comb begin
        count_next = count_reg;
        if (i_port_init) begin
            count_next = COUNT_RESET;
        end else begin
            unique case ({i_rx.char_in && !drop, i_rx.char_take && count_reg != 16'h0000})
                2'b10:   count_next = count_reg + 16'h0001;
                2'b01:   count_next = count_reg - 16'h0001;
                default: count_next = count_reg;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            count_reg <= COUNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rx_accept <= 1'b0;
        end else begin
            o_rx_accept <= !(count_reg >= DEPTH_W - 16'h0001);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive error flags; a new error wins over the query clear
    assign err_event[2] = i_rx.rx_overrun || drop;
    assign err_event[1] = i_rx.framing_err;
    assign err_event[0] = i_rx.parity_err;

    for (genvar g = 0; g < 3; g++) begin : g_err_flag
        always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
            if (!i_rst_n) begin
                err_reg[g] <= 1'b0;
            end else if (err_event[g]) begin
                err_reg[g] <= 1'b1;
            end else if (query) begin
                err_reg[g] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status word assembly
    always_comb begin
        status_word                    = STATUS_RESET;
        status_word[BIT_READ_ACTIVE]   = rd_act_reg;
        status_word[BIT_READ_DONE]     = rd_done_reg;
        status_word[BIT_READ_EXPIRED]  = rd_exp_reg;
        status_word[BIT_WRITE_ACTIVE]  = wr_act_reg;
        status_word[BIT_WRITE_DONE]    = wr_done_reg;
        status_word[BIT_WRITE_EXPIRED] = wr_exp_reg;
        status_word[BIT_RX_PENDING]    = count_reg != 16'h0000;
        status_word[BIT_OVERRUN]       = err_reg[2];
        status_word[BIT_FRAMING]       = err_reg[1];
        status_word[BIT_PARITY]        = err_reg[0];
        status_word[BIT_CTS]           = i_cts || !i_has_cts;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-word answer to a status query
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ans_state_reg  <= ANS_IDLE;
            o_ans_valid    <= 1'b0;
            o_ans_word     <= STATUS_RESET;
            count_snap_reg <= COUNT_RESET;
        end else begin
            unique case (ans_state_reg)
                ANS_IDLE: begin
                    o_ans_valid <= 1'b0;
                    if (query) begin
                        ans_state_reg  <= ANS_WORD1;
                        o_ans_valid    <= 1'b1;
                        o_ans_word     <= status_word;
                        count_snap_reg <= count_reg;
                    end
                end
                ANS_WORD1: begin
                    ans_state_reg <= ANS_WORD2;
                    o_ans_word    <= count_snap_reg;
                end
                ANS_WORD2: begin
                    ans_state_reg <= ANS_IDLE;
                    o_ans_valid   <= 1'b0;
                end
                default: begin
                    ans_state_reg <= ANS_IDLE;
                    o_ans_valid   <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // RTS command and line driver
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rts_cmd_reg <= RTS_RESET;
        end else if (i_port_init) begin
            rts_cmd_reg <= RTS_RESET;
        end else if (ctl_write) begin
            rts_cmd_reg <= i_cmd_word[BIT_RTS_CMD];
        end
    end

    // Non-RS-485 port keeps its driver on; unused duplex code acts as multi-drop
    always_comb begin
        drive_en_next = 1'b1;
        if (i_rs485) begin
            unique case (i_duplex)
                DUPLEX_P2P:   drive_en_next = 1'b1;
                DUPLEX_2WIRE: drive_en_next = i_tx_busy;
                DUPLEX_4WIRE: drive_en_next = i_tx_busy;
                default:      drive_en_next = i_tx_busy;
            endcase
        end
        rts_line_next = rts_cmd_reg && drive_en_next;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tx_drive_en <= 1'b0;
            o_rts         <= RTS_RESET;
        end else begin
            o_tx_drive_en <= drive_en_next;
            o_rts         <= rts_line_next;
        end
    end

endmodule : serial_port_status_control
